// ===== design/bmc_pkg.sv
package bmc_pkg;
  localparam logic [15:0] VEC_NMI = 16'hFFFA;
  localparam logic [15:0] VEC_RST = 16'hFFFC;
  localparam logic [15:0] VEC_IRQ = 16'hFFFE;
  localparam logic [7:0] RAM_BASE = 8'h40;
  localparam int RAM_BYTES = 192;
  localparam int KEEP_BYTES = 32;
  localparam logic [1:0] DIV_LAST = 2'h3;
  localparam logic [7:0] P_RESET = 8'h24;
  localparam int FL_C = 0;
  localparam int FL_I = 2;
  localparam int FL_B = 4;
  localparam int FL_V = 6;
  localparam int FL_N = 7;
  localparam logic [3:0] BIT_RMW_LO = 4'h7;
  localparam logic [3:0] BIT_BR_LO = 4'hF;
  localparam logic [7:0] SOFTWARE_BREAK_OP = 8'h00;
  localparam logic [7:0] OP_ORA_IMM = 8'h09;
  localparam logic [7:0] SUBROUTINE_CALL_OP = 8'h20;
  localparam logic [7:0] OP_AND_IMM = 8'h29;
  localparam logic [7:0] INTERRUPT_RETURN_OP = 8'h40;
  localparam logic [7:0] OP_PHA = 8'h48;
  localparam logic [7:0] OP_EOR_IMM = 8'h49;
  localparam logic [7:0] OP_JMP_ABS = 8'h4C;
  localparam logic [7:0] OP_CLI = 8'h58;
  localparam logic [7:0] OP_RTS = 8'h60;
  localparam logic [7:0] OP_PLA = 8'h68;
  localparam logic [7:0] OP_ADC_IMM = 8'h69;
  localparam logic [7:0] OP_SEI = 8'h78;
  localparam logic [7:0] OP_STA_ZP = 8'h85;
  localparam logic [7:0] OP_STA_ABS = 8'h8D;
  localparam logic [7:0] OP_STA_ZPX = 8'h95;
  localparam logic [7:0] OP_TXS = 8'h9A;
  localparam logic [7:0] OP_LDY_IMM = 8'hA0;
  localparam logic [7:0] OP_LDX_IMM = 8'hA2;
  localparam logic [7:0] OP_LDA_ZP = 8'hA5;
  localparam logic [7:0] OP_LDA_IMM = 8'hA9;
  localparam logic [7:0] OP_TAX = 8'hAA;
  localparam logic [7:0] OP_LDA_ABS = 8'hAD;
  localparam logic [7:0] OP_LDA_ZPX = 8'hB5;
  localparam logic [7:0] OP_DEX = 8'hCA;
  localparam logic [7:0] OP_INX = 8'hE8;

  typedef enum logic [2:0] {
    FIRST_CYCLE_STATE = 3'b000,
    CYC_1 = 3'b001,
    CYC_2 = 3'b010,
    CYC_3 = 3'b011,
    CYC_4 = 3'b100,
    CYC_5 = 3'b101,
    CYC_6 = 3'b110
  } bmc_cyc_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic rw;
    logic oe_n;
    logic opfetch;
  } bmc_bus_t;

  typedef struct packed {
    logic [7:0] data;
    logic nmi_n;
    logic [7:0] irq;
    logic standby;
  } bmc_pins_t;

  // one bus cycle; data driven exactly when writing
  function automatic bmc_bus_t f_bus(input logic [15:0] a, input logic rw, input logic [7:0] d, input logic f);
    f_bus = '{addr: a, data: d, rw: rw, oe_n: rw, opfetch: f};
  endfunction

  function automatic logic [7:0] f_nz(input logic [7:0] p, input logic [7:0] v);
    f_nz = p;
    f_nz[FL_N] = v[7];
    f_nz[1] = (v == 8'h00);
  endfunction

  function automatic logic f_in_ram(input logic [15:0] a);
    f_in_ram = (a[15:8] == 8'h00) && (a[7:0] >= RAM_BASE);
  endfunction

  function automatic logic f_is_bitop(input logic [7:0] op);
    f_is_bitop = (op[3:0] == BIT_RMW_LO) || (op[3:0] == BIT_BR_LO);
  endfunction
endpackage

// ===== design/bmc_core.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_core
  import bmc_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // external memory bus
  output logic [15:0] o_addr,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  input wire logic [7:0] i_data,
  output logic o_rw,
  output logic o_opfetch,
  output logic o_phase2,
  // interrupt sources and power state
  input wire logic i_nmi_n,
  input wire logic [7:0] i_irq_src,
  input wire logic i_standby
);

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] div_q;
  logic ph2_q;
  logic tick;
  bmc_pins_t pin_s1_q;
  bmc_pins_t pin_s2_q;
  logic nmi_prev_q;
  logic nmi_pend_q;
  logic irq_req;
  bmc_bus_t bus_q;
  bmc_cyc_t t_q;
  logic [7:0] a_q;
  logic [7:0] x_q;
  logic [7:0] y_q;
  logic [7:0] sp_q;
  logic [7:0] p_q;
  logic [15:0] pc_q;
  logic [7:0] ir_q;
  logic [15:0] ea_q;
  logic [15:0] vec_q;
  logic hw_q;
  logic bit_q;
  logic [7:0] ram_q [RAM_BYTES];
  logic [7:0] din;
  logic [7:0] alu;
  logic [7:0] p_alu;
  logic [8:0] sum;
  logic [7:0] bmask;
  logic [15:0] pc_inc;
  logic [15:0] rel16;

  // four clocks per cpu cycle leave room for the data synchroniser
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      div_q <= 2'h0;
      ph2_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      ph2_q <= div_q[1];
    end
  end
  assign tick = (div_q == DIV_LAST);

  // every pin but reset passes two flops before use; no reset, since standby
  // must still reach the ram while reset is held
  always_ff @(posedge i_ref_clk) begin
    pin_s1_q <= '{data: i_data, nmi_n: i_nmi_n, irq: i_irq_src, standby: i_standby};
    pin_s2_q <= pin_s1_q;
  end

  // falling edge latches nmi; a new edge beats the clear
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= pin_s2_q.nmi_n;
      nmi_pend_q <= (nmi_prev_q && !pin_s2_q.nmi_n) || (nmi_pend_q && !(tick && t_q == FIRST_CYCLE_STATE));
    end
  end
  assign irq_req = (|pin_s2_q.irq) && !p_q[FL_I];

  ////////////////////////////////////////////////////////////////////////
  // page-zero ram; power loss scrubs all but the retained bytes
  always_ff @(posedge i_ref_clk) begin
    if (pin_s2_q.standby) begin
      for (int i = KEEP_BYTES; i < RAM_BYTES; i++) begin
        ram_q[i] <= 8'h00;
      end
    end else if (tick && !bus_q.rw && f_in_ram(bus_q.addr)) begin
      ram_q[bus_q.addr[7:0] - RAM_BASE] <= bus_q.data;
    end
  end

  // internal ram answers its own range, everything else is external
  assign din = (bus_q.rw && f_in_ram(bus_q.addr)) ? ram_q[bus_q.addr[7:0] - RAM_BASE] : pin_s2_q.data;
  assign sum = {1'b0, a_q} + {1'b0, din} + {8'h00, p_q[FL_C]};
  assign bmask = 8'h01 << ir_q[6:4];
  assign pc_inc = pc_q + 16'h0001;
  assign rel16 = {{8{din[7]}}, din};

  // alu is combinational only; the tick stores its result
  always_comb begin
    alu = din;
    p_alu = p_q;
    case (ir_q)
      OP_AND_IMM: alu = a_q & din;
      OP_ORA_IMM: alu = a_q | din;
      OP_EOR_IMM: alu = a_q ^ din;
      OP_ADC_IMM: begin
        alu = sum[7:0];
        p_alu[FL_C] = sum[8];
        p_alu[FL_V] = (a_q[7] == din[7]) && (sum[7] != a_q[7]);
      end
      default: alu = din;
    endcase
    p_alu = f_nz(p_alu, alu);
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: opcode and cycle state pick each transfer
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      bus_q <= f_bus(VEC_RST, 1'b1, 8'h00, 1'b0);
      t_q <= CYC_5;
      ir_q <= SOFTWARE_BREAK_OP;
      vec_q <= VEC_RST;
      hw_q <= 1'b1;
      p_q <= P_RESET;
      pc_q <= 16'h0000;
      ea_q <= 16'h0000;
      a_q <= 8'h00;
      x_q <= 8'h00;
      y_q <= 8'h00;
      bit_q <= 1'b0;
    end else if (tick) begin
      unique case (t_q)
        FIRST_CYCLE_STATE: begin
          t_q <= CYC_1;
          if (nmi_pend_q || irq_req) begin
            ir_q <= SOFTWARE_BREAK_OP;
            hw_q <= 1'b1;
            vec_q <= nmi_pend_q ? VEC_NMI : VEC_IRQ;
            bus_q <= f_bus(pc_q, 1'b1, 8'h00, 1'b0);
          end else begin
            ir_q <= din;
            hw_q <= 1'b0;
            vec_q <= VEC_IRQ;
            pc_q <= pc_inc;
            bus_q <= f_bus(pc_inc, 1'b1, 8'h00, 1'b0);
          end
        end
        CYC_1: begin
          t_q <= CYC_2;
          case (ir_q)
            OP_LDA_IMM, OP_ADC_IMM, OP_AND_IMM, OP_ORA_IMM, OP_EOR_IMM: begin
              a_q <= alu;
              p_q <= p_alu;
              pc_q <= pc_inc;
              bus_q <= f_bus(pc_inc, 1'b1, 8'h00, 1'b1);
              t_q <= FIRST_CYCLE_STATE;
            end
            OP_LDX_IMM, OP_LDY_IMM: begin
              if (ir_q == OP_LDX_IMM) x_q <= din;
              else y_q <= din;
              p_q <= f_nz(p_q, din);
              pc_q <= pc_inc;
              bus_q <= f_bus(pc_inc, 1'b1, 8'h00, 1'b1);
              t_q <= FIRST_CYCLE_STATE;
            end
            OP_LDA_ZP, OP_STA_ZP, OP_LDA_ZPX, OP_STA_ZPX: begin
              pc_q <= pc_inc;
              if (ir_q[4]) bus_q <= f_bus({8'h00, din + x_q}, ir_q[5], a_q, 1'b0);
              else bus_q <= f_bus({8'h00, din}, ir_q[5], a_q, 1'b0);
            end
            OP_LDA_ABS, OP_STA_ABS, OP_JMP_ABS, SUBROUTINE_CALL_OP: begin
              ea_q[7:0] <= din;
              pc_q <= pc_inc;
              bus_q <= f_bus(pc_inc, 1'b1, 8'h00, 1'b0);
            end
            OP_PHA: bus_q <= f_bus({8'h00, sp_q}, 1'b0, a_q, 1'b0);
            OP_PLA, OP_RTS, INTERRUPT_RETURN_OP: begin
              sp_q <= sp_q + 8'h01;
              bus_q <= f_bus({8'h00, sp_q + 8'h01}, 1'b1, 8'h00, 1'b0);
            end
            SOFTWARE_BREAK_OP: begin
              if (!hw_q) pc_q <= pc_inc; // skip the padding byte of a software break
              bus_q <= f_bus({8'h00, sp_q}, 1'b0, hw_q ? pc_q[15:8] : pc_inc[15:8], 1'b0);
            end
            default: begin
              t_q <= FIRST_CYCLE_STATE;
              bus_q <= f_bus(pc_q, 1'b1, 8'h00, 1'b1);
              if (f_is_bitop(ir_q)) begin
                pc_q <= pc_inc;
                bus_q <= f_bus({8'h00, din}, 1'b1, 8'h00, 1'b0);
                t_q <= CYC_2;
              end
              if (ir_q == OP_TAX) x_q <= a_q;
              if (ir_q == OP_TAX) p_q <= f_nz(p_q, a_q);
              if (ir_q == OP_INX) x_q <= x_q + 8'h01;
              if (ir_q == OP_INX) p_q <= f_nz(p_q, x_q + 8'h01);
              if (ir_q == OP_DEX) x_q <= x_q - 8'h01;
              if (ir_q == OP_DEX) p_q <= f_nz(p_q, x_q - 8'h01);
              if (ir_q == OP_TXS) sp_q <= x_q;
              if (ir_q == OP_SEI || ir_q == OP_CLI) p_q[FL_I] <= ir_q[5];
            end
          endcase
        end
        CYC_2: begin
          t_q <= CYC_3;
          case (ir_q)
            OP_LDA_ZP, OP_LDA_ZPX, OP_PLA: begin
              a_q <= alu;
              p_q <= p_alu;
              bus_q <= f_bus(pc_q, 1'b1, 8'h00, 1'b1);
              t_q <= FIRST_CYCLE_STATE;
            end
            OP_STA_ZP, OP_STA_ZPX, OP_PHA: begin
              if (ir_q == OP_PHA) sp_q <= sp_q - 8'h01;
              bus_q <= f_bus(pc_q, 1'b1, 8'h00, 1'b1);
              t_q <= FIRST_CYCLE_STATE;
            end
            OP_LDA_ABS, OP_STA_ABS: begin
              pc_q <= pc_inc;
              bus_q <= f_bus({din, ea_q[7:0]}, ir_q == OP_LDA_ABS, a_q, 1'b0);
            end
            OP_JMP_ABS: begin
              pc_q <= {din, ea_q[7:0]};
              bus_q <= f_bus({din, ea_q[7:0]}, 1'b1, 8'h00, 1'b1);
              t_q <= FIRST_CYCLE_STATE;
            end
            SUBROUTINE_CALL_OP: begin
              ea_q[15:8] <= din;
              bus_q <= f_bus({8'h00, sp_q}, 1'b0, pc_q[15:8], 1'b0);
            end
            OP_RTS, INTERRUPT_RETURN_OP: begin
              if (ir_q == INTERRUPT_RETURN_OP) p_q <= din;
              else ea_q[7:0] <= din;
              sp_q <= sp_q + 8'h01;
              bus_q <= f_bus({8'h00, sp_q + 8'h01}, 1'b1, 8'h00, 1'b0);
            end
            SOFTWARE_BREAK_OP: begin
              sp_q <= sp_q - 8'h01;
              bus_q <= f_bus({8'h00, sp_q - 8'h01}, 1'b0, pc_q[7:0], 1'b0);
            end
            default: begin
              if (ir_q[3:0] == BIT_RMW_LO) begin
                // write the byte just read back with the opcode's bit set or cleared; flags stay put
                bus_q <= f_bus(bus_q.addr, 1'b0, ir_q[7] ? (din | bmask) : (din & ~bmask), 1'b0);
              end else begin
                bit_q <= |(din & bmask);
                bus_q <= f_bus(pc_q, 1'b1, 8'h00, 1'b0);
              end
            end
          endcase
        end
        CYC_3: begin
          t_q <= FIRST_CYCLE_STATE;
          bus_q <= f_bus(pc_q, 1'b1, 8'h00, 1'b1);
          case (ir_q)
            OP_LDA_ABS: begin
              a_q <= alu;
              p_q <= p_alu;
            end
            SUBROUTINE_CALL_OP: begin
              sp_q <= sp_q - 8'h01;
              bus_q <= f_bus({8'h00, sp_q - 8'h01}, 1'b0, pc_q[7:0], 1'b0);
              t_q <= CYC_4;
            end
            OP_RTS: begin
              pc_q <= {din, ea_q[7:0]} + 16'h0001;
              bus_q <= f_bus({din, ea_q[7:0]} + 16'h0001, 1'b1, 8'h00, 1'b1);
            end
            INTERRUPT_RETURN_OP: begin
              ea_q[7:0] <= din;
              sp_q <= sp_q + 8'h01;
              bus_q <= f_bus({8'h00, sp_q + 8'h01}, 1'b1, 8'h00, 1'b0);
              t_q <= CYC_4;
            end
            SOFTWARE_BREAK_OP: begin
              sp_q <= sp_q - 8'h01;
              // break bit comes from the entry source, never from a pulled status
              bus_q <= f_bus({8'h00, sp_q - 8'h01}, 1'b0, {p_q[7:5], !hw_q, p_q[3:0]}, 1'b0);
              t_q <= CYC_4;
            end
            default: begin
              if (ir_q[3:0] == BIT_BR_LO) begin
                // taken when the tested bit matches the opcode's sense
                pc_q <= (bit_q == ir_q[7]) ? pc_inc + rel16 : pc_inc;
                bus_q <= f_bus((bit_q == ir_q[7]) ? pc_inc + rel16 : pc_inc, 1'b1, 8'h00, 1'b1);
              end
            end
          endcase
        end
        CYC_4: begin
          t_q <= FIRST_CYCLE_STATE;
          if (ir_q == SUBROUTINE_CALL_OP) begin
            sp_q <= sp_q - 8'h01;
            pc_q <= ea_q;
            bus_q <= f_bus(ea_q, 1'b1, 8'h00, 1'b1);
          end else if (ir_q == INTERRUPT_RETURN_OP) begin
            pc_q <= {din, ea_q[7:0]};
            bus_q <= f_bus({din, ea_q[7:0]}, 1'b1, 8'h00, 1'b1);
          end else begin
            sp_q <= sp_q - 8'h01;
            p_q[FL_I] <= 1'b1;
            bus_q <= f_bus(vec_q, 1'b1, 8'h00, 1'b0);
            t_q <= CYC_5;
          end
        end
        CYC_5: begin
          ea_q[7:0] <= din;
          bus_q <= f_bus(vec_q + 16'h0001, 1'b1, 8'h00, 1'b0);
          t_q <= CYC_6;
        end
        CYC_6: begin
          pc_q <= {din, ea_q[7:0]};
          bus_q <= f_bus({din, ea_q[7:0]}, 1'b1, 8'h00, 1'b1);
          t_q <= FIRST_CYCLE_STATE;
        end
        default: begin
          bus_q <= f_bus(pc_q, 1'b1, 8'h00, 1'b1);
          t_q <= FIRST_CYCLE_STATE;
        end
      endcase
    end
  end

  assign o_addr = bus_q.addr;
  assign o_data = bus_q.data;
  assign o_data_oe_n = bus_q.oe_n;
  assign o_rw = bus_q.rw;
  assign o_opfetch = bus_q.opfetch;
  assign o_phase2 = ph2_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  sequence s_rmw_read;
    tick && t_q == CYC_2 && ir_q[3:0] == BIT_RMW_LO;
  endsequence
  sequence s_branch_taken;
    tick && t_q == CYC_3 && ir_q[3:0] == BIT_BR_LO && bit_q == ir_q[7];
  endsequence

  property p_push;
    (tick && t_q == CYC_2 && ir_q == OP_PHA) |-> (!o_rw && o_addr == {8'h00, sp_q}) ##1 (sp_q == $past(sp_q) - 8'h01);
  endproperty
  a_push: assert property (p_push) else $error("push order wrong");
  property p_pull;
    (tick && t_q == CYC_1 && ir_q == OP_PLA) |=> (sp_q == $past(sp_q) + 8'h01) && o_rw && o_addr == {8'h00, sp_q};
  endproperty
  a_pull: assert property (p_pull) else $error("pull order wrong");
  property p_fetch_flag;
    o_opfetch |-> (t_q == FIRST_CYCLE_STATE && o_rw && o_addr == pc_q);
  endproperty
  a_fetch_flag: assert property (p_fetch_flag) else $error("fetch flag off cycle");
  property p_cycle_hold;
    !tick |=> $stable(t_q) && $stable(o_addr);
  endproperty
  a_cycle_hold: assert property (p_cycle_hold) else $error("cycle moved between ticks");
  property p_pc_step;
    (tick && t_q == FIRST_CYCLE_STATE && !nmi_pend_q && !irq_req) |=> pc_q == $past(pc_q) + 16'h0001 && t_q == CYC_1;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("counter did not advance");
  property p_bit_flags;
    (tick && f_is_bitop(ir_q) && t_q != FIRST_CYCLE_STATE) |=> $stable(p_q);
  endproperty
  a_bit_flags: assert property (p_bit_flags) else $error("bit op changed flags");
  property p_rmw;
    s_rmw_read |=> !o_rw && o_data == (ir_q[7] ? ($past(din) | bmask) : ($past(din) & ~bmask));
  endproperty
  a_rmw: assert property (p_rmw) else $error("bit write-back wrong");
  property p_branch;
    s_branch_taken |=> pc_q == $past(pc_q) + 16'h0001 + $past(rel16);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");
  property p_adc;
    (tick && t_q == CYC_1 && ir_q == OP_ADC_IMM) |=> a_q == $past(sum[7:0]);
  endproperty
  a_adc: assert property (p_adc) else $error("sum not stored next cycle");
  property p_dir;
    !o_rw |-> !o_data_oe_n;
  endproperty
  a_dir: assert property (p_dir) else $error("write without drive");

endmodule
`default_nettype wire

// ===== test/bmc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmc_mem_model
  import bmc_pkg::*;
(
  // clock and pacing
  input wire logic i_ref_clk,
  input wire logic i_slow,
  // core side of the bus
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rw,
  input wire logic i_opfetch,
  output logic [7:0] o_rdata,
  // cycle events for the bench
  output logic o_wr_new,
  output logic o_fetch_new
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_q = 16'h0000;
  logic rw_q = 1'b1;
  logic [7:0] last_q = 8'h00;
  logic new_cyc;

  ////////////////////////////////////////////////////////////////
  // a cycle starts when address or direction moves
  assign new_cyc = (i_addr != addr_q) || (i_rw != rw_q);
  assign o_wr_new = new_cyc && !i_rw;
  assign o_fetch_new = new_cyc && i_opfetch;

  // released or unselected bus toggles, so stale data never matches
  always_comb begin
    if (!i_rw || f_in_ram(i_addr) || (i_slow && new_cyc)) begin
      o_rdata = ~last_q;
    end else begin
      o_rdata = mem[i_addr];
    end
  end

  // one store per write cycle, even though the address stands 4 clocks
  always @(posedge i_ref_clk) begin
    addr_q <= i_addr;
    rw_q <= i_rw;
    last_q <= o_rdata;
    if (o_wr_new) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule
`default_nettype wire

// ===== test/test_bit_manip_cpu_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_bit_manip_cpu_core;
  import bmc_pkg::*;
  localparam int LIMIT = 30000;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_nmi_n = 1'b1;
  logic i_standby = 1'b0;
  logic slow = 1'b0;
  logic [7:0] i_irq_src = 8'h00;
  logic [15:0] o_addr;
  logic [7:0] o_data;
  logic [7:0] rdata;
  logic o_data_oe_n, o_rw, o_opfetch, o_phase2, wr_new, fetch_new;
  logic [23:0] wq[$];
  logic [15:0] fq[$];
  logic [15:0] pc;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'h57f8;

  bmc_core i_dut(.i_ref_clk(i_ref_clk), .i_reset(i_reset), .o_addr(o_addr), .o_data(o_data),
    .o_data_oe_n(o_data_oe_n), .i_data(rdata), .o_rw(o_rw), .o_opfetch(o_opfetch), .o_phase2(o_phase2),
    .i_nmi_n(i_nmi_n), .i_irq_src(i_irq_src), .i_standby(i_standby));
  bmc_mem_model i_mem(.i_ref_clk(i_ref_clk), .i_slow(slow), .i_addr(o_addr), .i_wdata(o_data), .i_rw(o_rw),
    .i_opfetch(o_opfetch), .o_rdata(rdata), .o_wr_new(wr_new), .o_fetch_new(fetch_new));

  always #50 i_ref_clk = ~i_ref_clk;

  ////////////////////////////////////////////////////////////////
  // log bus events; a hang ends at the cycle ceiling
  always @(posedge i_ref_clk) begin
    cycles++;
    if (wr_new) begin
      wq.push_back({o_addr, o_data});
    end
    if (fetch_new) begin
      fq.push_back(o_addr);
    end
    if (cycles == LIMIT) begin
      fail("run limit reached");
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    num_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  // bounded wait for a logged event
  task automatic wait_q(input bit wr);
    int n;
    n = 0;
    while ((wr ? wq.size() : fq.size()) == 0 && n < 600) begin
      @(posedge i_ref_clk);
      n++;
    end
  endtask

  task automatic cmp_wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    logic [23:0] g;
    wait_q(1'b1);
    total_checks++;
    if (wq.size() == 0) begin
      fail($sformatf("no write, wanted %h", a));
    end else begin
      g = wq.pop_front();
      if (g[23:8] !== a || (g[7:0] & m) !== (d & m)) begin
        fail($sformatf("write %h=%h, wanted %h=%h", g[23:8], g[7:0], a, d));
      end
    end
  endtask

  task automatic cmp_fetch(input logic [15:0] a);
    logic [15:0] g;
    wait_q(1'b0);
    total_checks++;
    g = (fq.size() == 0) ? 16'hxxxx : fq.pop_front();
    if (g !== a) begin
      fail($sformatf("fetch at %h, wanted %h", g, a));
    end
  endtask

  task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail($sformatf("%s %h, wanted %h", what, got, exp));
    end
  endtask

  task automatic emit(input logic [7:0] x, input logic [7:0] y, input int n);
    i_mem.mem[pc] = x;
    if (n > 1) begin
      i_mem.mem[pc + 16'h0001] = y;
    end
    pc = pc + 16'(n);
  endtask

  // status pushed by a break: reset flags plus break, n and z of the load
  function automatic logic [7:0] f_flags(input logic [7:0] v);
    return 8'h34 | (v & 8'h80) | ((v == 8'h00) ? 8'h02 : 8'h00);
  endfunction

  ////////////////////////////////////////////////////////////////
  // each pass: reset (maybe through standby), load program, follow writes
  initial begin
    logic [31:0] r;
    logic [7:0] v1, v2, v4, pv2, pv4, a, ex, m;
    logic [4:0] k;
    logic [2:0] b, c, tb, td;
    logic [15:0] brk_at, jsr_at, loop_at, nmi_loop;
    logic sb;
    pv2 = 8'h00;
    pv4 = 8'h00;
    repeat (5) @(posedge i_ref_clk);
    for (int it = 0; it < 12; it++) begin
      r = $random(seed);
      {v1, v2, k, b, c} = r[26:0];
      r = $random(seed);
      i_reset <= 1'b1;
      i_nmi_n <= 1'b1;
      i_irq_src <= r[15:8] | 8'h01;
      slow <= r[0];
      sb = r[1] && (it > 0);
      tb = r[4:2];
      td = r[7:5];
      repeat (32) @(posedge i_ref_clk);
      if (sb) begin
        i_standby <= 1'b1;
        repeat (8) @(posedge i_ref_clk);
        i_standby <= 1'b0;
        repeat (32) @(posedge i_ref_clk);
      end
      cmp_pin(o_addr, VEC_RST, "reset address");
      cmp_pin({15'h0000, o_rw}, 16'h0001, "reset direction");
      cmp_pin({15'h0000, o_opfetch}, 16'h0000, "reset fetch flag");
      cmp_pin({15'h0000, o_data_oe_n}, 16'h0001, "reset data enable");
      cmp_pin({15'h0000, o_phase2}, 16'h0000, "reset phase clock");
      pc = 16'h0200;
      emit(OP_LDA_ZP, 8'h45, 2);
      emit(OP_STA_ZP, 8'h36, 2);
      emit(OP_LDA_ZP, 8'hF0, 2);
      emit(OP_STA_ZP, 8'h37, 2);
      emit(OP_LDX_IMM, 8'hFF, 2);
      emit(OP_TXS, 8'h00, 1);
      emit(OP_LDA_IMM, v1, 2);
      emit(OP_PHA, 8'h00, 1);
      emit(OP_LDA_IMM, 8'h00, 2);
      emit(OP_ADC_IMM, v2, 2);
      emit(OP_PLA, 8'h00, 1);
      emit(OP_STA_ZP, 8'h30, 2);
      emit(OP_LDX_IMM, {3'b000, k}, 2);
      emit(OP_STA_ZPX, 8'h20, 2);
      emit(OP_LDA_IMM, v2, 2);
      emit(OP_STA_ZP, 8'h45, 2);
      emit(OP_STA_ZP, 8'hF0, 2);
      emit({1'b1, b, BIT_RMW_LO}, 8'h45, 2);
      emit({1'b0, c, BIT_RMW_LO}, 8'h45, 2);
      brk_at = pc;
      emit(SOFTWARE_BREAK_OP, 8'hEA, 2);
      emit({1'b1, tb, BIT_BR_LO}, 8'h45, 2);
      emit(8'h04, 8'h00, 1);
      emit(OP_LDA_IMM, 8'h55, 2);
      emit(OP_STA_ZP, 8'h31, 2);
      emit(OP_STA_ZP, 8'h32, 2);
      emit({1'b0, td, BIT_BR_LO}, 8'h45, 2);
      emit(8'h04, 8'h00, 1);
      emit(OP_LDA_IMM, 8'h66, 2);
      emit(OP_STA_ZP, 8'h33, 2);
      emit(OP_STA_ZP, 8'h34, 2);
      jsr_at = pc;
      emit(SUBROUTINE_CALL_OP, 8'h00, 2);
      emit(8'h03, 8'h00, 1);
      loop_at = pc;
      emit(OP_JMP_ABS, loop_at[7:0], 2);
      emit(loop_at[15:8], 8'h00, 1);
      pc = 16'h0300;
      emit(OP_RTS, 8'h00, 1);
      pc = 16'h0310;
      emit(INTERRUPT_RETURN_OP, 8'h00, 1);
      pc = 16'h0320;
      emit(OP_LDA_IMM, 8'h77, 2);
      emit(OP_STA_ZP, 8'h3E, 2);
      emit(OP_CLI, 8'h00, 1);
      nmi_loop = pc;
      emit(OP_JMP_ABS, nmi_loop[7:0], 2);
      emit(nmi_loop[15:8], 8'h00, 1);
      pc = VEC_NMI;
      emit(8'h20, 8'h03, 2);
      emit(8'h00, 8'h02, 2);
      emit(8'h10, 8'h03, 2);
      wq.delete();
      fq.delete();
      i_reset <= 1'b0;
      cmp_fetch(16'h0200);
      cmp_fetch(16'h0202);
      m = (it > 0) ? 8'hFF : 8'h00;
      cmp_wr(16'h0036, pv4, m);
      cmp_wr(16'h0037, sb ? 8'h00 : pv2, m);
      cmp_wr(16'h00FF, v1, 8'hFF);
      cmp_wr(16'h0030, v1, 8'hFF);
      cmp_wr(16'h0020 + {11'h000, k}, v1, 8'hFF);
      cmp_wr(16'h0045, v2, 8'hFF);
      cmp_wr(16'h00F0, v2, 8'hFF);
      ex = v2;
      ex[b] = 1'b1;
      cmp_wr(16'h0045, ex, 8'hFF);
      ex[c] = 1'b0;
      v4 = ex;
      cmp_wr(16'h0045, v4, 8'hFF);
      cmp_wr(16'h00FF, 8'h02, 8'hFF);
      cmp_wr(16'h00FE, brk_at[7:0] + 8'h02, 8'hFF);
      cmp_wr(16'h00FD, f_flags(v2), 8'hFF);
      a = v2;
      if (!v4[tb]) begin
        cmp_wr(16'h0031, 8'h55, 8'hFF);
        a = 8'h55;
      end
      cmp_wr(16'h0032, a, 8'hFF);
      if (v4[td]) begin
        cmp_wr(16'h0033, 8'h66, 8'hFF);
        a = 8'h66;
      end
      cmp_wr(16'h0034, a, 8'hFF);
      cmp_wr(16'h00FF, 8'h02, 8'hFF);
      cmp_wr(16'h00FE, jsr_at[7:0] + 8'h02, 8'hFF);
      // let the return finish so the request lands in the idle loop
      repeat (80) @(posedge i_ref_clk);
      i_nmi_n <= 1'b0;
      repeat (8) @(posedge i_ref_clk);
      i_nmi_n <= 1'b1;
      cmp_wr(16'h00FF, loop_at[15:8], 8'hFF);
      cmp_wr(16'h00FE, loop_at[7:0], 8'hFF);
      cmp_wr(16'h00FD, 8'h04, 8'h14);
      cmp_wr(16'h003E, 8'h77, 8'hFF);
      cmp_wr(16'h00FC, nmi_loop[15:8], 8'hFF);
      cmp_wr(16'h00FB, nmi_loop[7:0], 8'hFF);
      cmp_wr(16'h00FA, 8'h00, 8'h14);
      pv2 = v2;
      pv4 = v4;
    end
    summarize();
  end
endmodule
`default_nettype wire
